// *** verilog/sas_pkg.sv ***
`default_nettype none
package sas_pkg;
	localparam logic [7:0] OFF_CTL1 = 8'h00;
	localparam logic [7:0] OFF_CTL2 = 8'h04;
	localparam logic [7:0] OFF_CTL3 = 8'h08;
	localparam logic [7:0] OFF_BUF0 = 8'h0c;
	localparam logic [7:0] OFF_BUF1 = 8'h10;
	localparam logic [15:0] CTL1_WMASK = 16'ha3e6;
	localparam logic [15:0] CTL2_WMASK = 16'hf43d;
	localparam logic [15:0] CTL3_WMASK = 16'hbf3f;
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam int RES_W = 10;
	localparam int BUF_WORDS = 2;
	localparam int NSYNC = 5;
	localparam logic [2:0] TRIG_SOFT = 3'h0;
	localparam logic [2:0] TRIG_PIN = 3'h1;
	localparam logic [2:0] TRIG_TIMER = 3'h2;
	localparam logic [2:0] TRIG_AUTO = 3'h7;
	localparam logic [1:0] FMT_INT = 2'h0;
	localparam logic [1:0] FMT_SINT = 2'h1;
	localparam logic [1:0] FMT_FRAC = 2'h2;
	localparam logic [1:0] FMT_SFRAC = 2'h3;
	localparam logic [2:0] REF_POS_EXT = 3'h1;
	localparam logic [2:0] REF_NEG_EXT = 3'h2;
	localparam logic [2:0] REF_BOTH_EXT = 3'h3;
	localparam logic [4:0] SAMPLE_TIME_MAX = 5'h1f;
	localparam logic [9:0] SIGN_FLIP = 10'h200;

	typedef enum logic [2:0] {SEL_NONE, SEL_CTL1, SEL_CTL2, SEL_CTL3, SEL_BUF0, SEL_BUF1} sas_sel_t;
	typedef enum logic [1:0] {ST_OFF, ST_HOLD, ST_SAMPLE, ST_CONVERT} sas_state_t;

	typedef struct packed {
		logic       moduleOn;
		logic       rsv14;
		logic       stopInIdle;
		logic [2:0] rsv12;
		logic [1:0] outputFormat;
		logic [2:0] triggerSource;
		logic [1:0] rsv4;
		logic       autoSampleStart;
		logic       sampleEnable;
		logic       done;
	} sas_ctl1_t;

	typedef struct packed {
		logic [2:0] referenceSelect;
		logic       offsetCalibration;
		logic       rsv11;
		logic       scanEnable;
		logic [3:0] rsv9;
		logic [3:0] interruptRate;
		logic       rsv1;
		logic       alternateInput;
	} sas_ctl2_t;

	typedef struct packed {
		logic       clockSourceRc;
		logic       extendedSampling;
		logic       chargePumpEnable;
		logic [4:0] autoSampleTime;
		logic [1:0] rsv7;
		logic [5:0] convClockSelect;
	} sas_ctl3_t;
endpackage
`default_nettype wire

// *** verilog/sas_tad_div.sv ***
`default_nettype none
module sas_conv_div (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       run,
	input  wire logic [5:0] divSel,
	output logic            tick
);
	logic [5:0] cnt_reg;
	logic       tick_reg;
	wire        wrap = (cnt_reg >= divSel);

	// period is divSel+1 core clocks, so code 0 ticks every cycle
	always_ff @(posedge core_clk) begin
		if (reset || !run) begin
			cnt_reg <= 6'h00;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= wrap ? 6'h00 : cnt_reg + 6'h01;
			tick_reg <= wrap;
		end
	end

	assign tick = tick_reg;
endmodule
`default_nettype wire

// *** verilog/sas_sequencer.sv ***
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`default_nettype none
module sas_sequencer (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        idleMode,
	input  wire logic        timerMatch,
	input  wire logic        extIntZero,
	input  wire logic        rcClock,
	input  wire logic        convDone,
	input  wire logic [9:0]  convResult,
	output logic             sampling,
	output logic             convStart,
	output logic             muxSelB,
	output logic             scanStep,
	output logic             refPosExt,
	output logic             refNegExt,
	output logic             calibrate,
	output logic             pumpOn,
	output logic             rcSelect,
	output logic             converterIntFlag,
	output logic             moduleActive
);
	// whole-word bus only; hsize is not needed for decode
	sas_pkg::sas_ctl1_t  ctl1_reg;
	sas_pkg::sas_ctl1_t  ctl1_next;
	sas_pkg::sas_ctl2_t  ctl2_reg;
	sas_pkg::sas_ctl3_t  ctl3_reg;
	sas_pkg::sas_state_t state_reg;
	sas_pkg::sas_state_t state_next;
	sas_pkg::sas_sel_t   wrSel_reg;

	logic [15:0] resBuf_reg [sas_pkg::BUF_WORDS];
	logic        bufIdx_reg;
	logic        bufIdx_next;
	logic [3:0]  seqCnt_reg;
	logic [3:0]  seqCnt_next;
	logic [4:0]  sampleCnt_reg;
	logic [4:0]  sampleCnt_next;
	logic        muxB_reg;
	logic        muxB_next;
	logic        resultWr;
	logic        intPulse_next;
	logic        convStart_next;
	logic        scanStep_next;
	logic        wrPend_reg;
	logic [31:0] hrdata_reg;
	logic        hreadyout_reg;
	logic        sampling_reg;
	logic        convStart_reg;
	logic        muxSelB_reg;
	logic        scanStep_reg;
	logic        refPosExt_reg;
	logic        refNegExt_reg;
	logic        calibrate_reg;
	logic        pumpOn_reg;
	logic        rcSelect_reg;
	logic        intFlag_reg;
	logic        active_reg;

	logic [sas_pkg::NSYNC-1:0] syncA_reg;
	logic [sas_pkg::NSYNC-1:0] syncB_reg;
	logic [sas_pkg::NSYNC-1:0] syncC_reg;
	wire  [sas_pkg::NSYNC-1:0] pinIn = {convDone, rcClock, extIntZero, timerMatch, idleMode};

	function automatic sas_pkg::sas_sel_t sas_decode(input logic [31:0] addr);
		sas_pkg::sas_sel_t sel;
		sel = sas_pkg::SEL_NONE;
		if (addr[31:8] == 24'h000000) begin
			unique case (addr[7:0])
				sas_pkg::OFF_CTL1: sel = sas_pkg::SEL_CTL1;
				sas_pkg::OFF_CTL2: sel = sas_pkg::SEL_CTL2;
				sas_pkg::OFF_CTL3: sel = sas_pkg::SEL_CTL3;
				sas_pkg::OFF_BUF0: sel = sas_pkg::SEL_BUF0;
				sas_pkg::OFF_BUF1: sel = sas_pkg::SEL_BUF1;
				default: sel = sas_pkg::SEL_NONE;
			endcase
		end
		return sel;
	endfunction

	function automatic logic [15:0] sas_format(input logic [1:0] fmt, input logic [9:0] raw);
		logic [9:0]  sgn;
		logic [15:0] word;
		sgn = raw ^ sas_pkg::SIGN_FLIP;
		unique case (fmt)
			sas_pkg::FMT_INT: word = {6'h00, raw};
			sas_pkg::FMT_SINT: word = {{6{sgn[9]}}, sgn};
			sas_pkg::FMT_FRAC: word = {raw, 6'h00};
			sas_pkg::FMT_SFRAC: word = {sgn, 6'h00};
		endcase
		return word;
	endfunction

	// pins and the rc clock come from outside this domain
	genvar gi;
	generate
		for (gi = 0; gi < sas_pkg::NSYNC; gi++) begin : g_sync
			always_ff @(posedge core_clk) begin
				if (reset) begin
					syncA_reg[gi] <= 1'b0;
					syncB_reg[gi] <= 1'b0;
					syncC_reg[gi] <= 1'b0;
				end else begin
					syncA_reg[gi] <= pinIn[gi];
					syncB_reg[gi] <= syncA_reg[gi];
					syncC_reg[gi] <= syncB_reg[gi];
				end
			end
		end
	endgenerate

	wire idleSync = syncB_reg[0];
	wire timerRise = syncB_reg[1] && !syncC_reg[1];
	wire extRise = syncB_reg[2] && !syncC_reg[2];
	wire rcRise = syncB_reg[3] && !syncC_reg[3];
	wire doneRise = syncB_reg[4] && !syncC_reg[4];

	// bus decode
	wire                busGo = hsel && htrans[1] && hready;
	sas_pkg::sas_sel_t  busSel;
	assign busSel = sas_decode(haddr);
	wire [15:0] wrWord = hwdata[15:0];
	wire wrCtl1 = wrPend_reg && (wrSel_reg == sas_pkg::SEL_CTL1);
	wire wrCtl2 = wrPend_reg && (wrSel_reg == sas_pkg::SEL_CTL2);
	wire wrCtl3 = wrPend_reg && (wrSel_reg == sas_pkg::SEL_CTL3);

	wire extSampling = (state_reg == sas_pkg::ST_SAMPLE) && !ctl1_reg.sampleEnable;
	wire [15:0] ctl3View = {ctl3_reg[15], extSampling, ctl3_reg[13:0]};
	wire [15:0] rdWord =
		(busSel == sas_pkg::SEL_CTL1) ? ctl1_reg :
		(busSel == sas_pkg::SEL_CTL2) ? ctl2_reg :
		(busSel == sas_pkg::SEL_CTL3) ? ctl3View :
		(busSel == sas_pkg::SEL_BUF0) ? resBuf_reg[0] :
		(busSel == sas_pkg::SEL_BUF1) ? resBuf_reg[1] :
		16'h0000;

	// conversion clock
	wire divTick;
	sas_conv_div u_div (
		.core_clk (core_clk),
		.reset    (reset),
		.run      (ctl1_reg.moduleOn),
		.divSel   (ctl3_reg.convClockSelect),
		.tick     (divTick)
	);
	wire convTick = ctl3_reg.clockSourceRc ? rcRise : divTick;

	// halting in idle freezes the sequence where it stands
	wire idleHalt = ctl1_reg.stopInIdle && idleSync;
	wire calOn = ctl2_reg.offsetCalibration;
	wire autoDone = (sampleCnt_reg >= ctl3_reg.autoSampleTime);

	logic trigger;
	always_comb begin
		unique case (ctl1_reg.triggerSource)
			sas_pkg::TRIG_SOFT: trigger = !ctl1_reg.sampleEnable;
			sas_pkg::TRIG_PIN: trigger = extRise;
			sas_pkg::TRIG_TIMER: trigger = timerRise;
			sas_pkg::TRIG_AUTO: trigger = autoDone;
			default: trigger = 1'b0;
		endcase
	end

	always_comb begin
		ctl1_next = ctl1_reg;
		if (wrCtl1) begin
			ctl1_next = sas_pkg::sas_ctl1_t'(wrWord & sas_pkg::CTL1_WMASK);
			ctl1_next.done = ctl1_reg.done;
		end
		state_next = state_reg;
		bufIdx_next = bufIdx_reg;
		seqCnt_next = seqCnt_reg;
		sampleCnt_next = sampleCnt_reg;
		muxB_next = muxB_reg;
		resultWr = 1'b0;
		intPulse_next = 1'b0;
		convStart_next = 1'b0;
		scanStep_next = 1'b0;
		// hardware updates follow the software write, so they win
		if (!ctl1_reg.moduleOn) begin
			state_next = sas_pkg::ST_OFF;
			ctl1_next.sampleEnable = 1'b0;
			bufIdx_next = 1'b0;
			seqCnt_next = 4'h0;
			muxB_next = 1'b0;
		end else if (!idleHalt) begin
			unique case (state_reg)
				sas_pkg::ST_OFF: begin
					state_next = sas_pkg::ST_HOLD;
				end
				sas_pkg::ST_HOLD: begin
					// hold leaves sample_enable alone so a software set here survives
					if (ctl1_reg.sampleEnable || ctl1_reg.autoSampleStart) begin
						state_next = sas_pkg::ST_SAMPLE;
						ctl1_next.sampleEnable = 1'b1;
						sampleCnt_next = 5'h00;
					end
				end
				sas_pkg::ST_SAMPLE: begin
					if (convTick && sampleCnt_reg != sas_pkg::SAMPLE_TIME_MAX) begin
						sampleCnt_next = sampleCnt_reg + 5'h01;
					end
					if (trigger) begin
						state_next = sas_pkg::ST_CONVERT;
						ctl1_next.sampleEnable = 1'b0;
						ctl1_next.done = 1'b0;
						convStart_next = 1'b1;
					end
				end
				sas_pkg::ST_CONVERT: begin
					ctl1_next.sampleEnable = 1'b0;
					if (doneRise) begin
						resultWr = 1'b1;
						ctl1_next.done = 1'b1;
						bufIdx_next = !bufIdx_reg;
						// rate 1111 wraps the two-word buffer and loses data
						if (seqCnt_reg >= ctl2_reg.interruptRate) begin
							seqCnt_next = 4'h0;
							intPulse_next = 1'b1;
						end else begin
							seqCnt_next = seqCnt_reg + 4'h1;
						end
						muxB_next = ctl2_reg.alternateInput && !calOn && !muxB_reg;
						scanStep_next = ctl2_reg.scanEnable && !calOn && !muxB_reg;
						if (ctl1_reg.autoSampleStart) begin
							state_next = sas_pkg::ST_SAMPLE;
							ctl1_next.sampleEnable = 1'b1;
							sampleCnt_next = 5'h00;
						end else begin
							state_next = sas_pkg::ST_HOLD;
						end
					end
				end
			endcase
		end
	end

	// bus slave: zero wait, always okay
	always_ff @(posedge core_clk) begin
		if (reset) begin
			wrPend_reg <= 1'b0;
			wrSel_reg <= sas_pkg::SEL_NONE;
			hrdata_reg <= 32'h00000000;
			hreadyout_reg <= 1'b1;
		end else begin
			wrPend_reg <= busGo && hwrite;
			hreadyout_reg <= 1'b1;
			if (busGo) begin
				wrSel_reg <= busSel;
			end
			if (busGo && !hwrite) begin
				hrdata_reg <= {16'h0000, rdWord};
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctl1_reg <= sas_pkg::sas_ctl1_t'(sas_pkg::CTL_RESET);
			ctl2_reg <= sas_pkg::sas_ctl2_t'(sas_pkg::CTL_RESET);
			ctl3_reg <= sas_pkg::sas_ctl3_t'(sas_pkg::CTL_RESET);
		end else begin
			ctl1_reg <= ctl1_next;
			if (wrCtl2) begin
				ctl2_reg <= sas_pkg::sas_ctl2_t'(wrWord & sas_pkg::CTL2_WMASK);
			end
			if (wrCtl3) begin
				ctl3_reg <= sas_pkg::sas_ctl3_t'(wrWord & sas_pkg::CTL3_WMASK);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= sas_pkg::ST_OFF;
			bufIdx_reg <= 1'b0;
			seqCnt_reg <= 4'h0;
			sampleCnt_reg <= 5'h00;
			muxB_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			bufIdx_reg <= bufIdx_next;
			seqCnt_reg <= seqCnt_next;
			sampleCnt_reg <= sampleCnt_next;
			muxB_reg <= muxB_next;
		end
	end

	// result words; contents are dropped whenever the module is off
	genvar bi;
	generate
		for (bi = 0; bi < sas_pkg::BUF_WORDS; bi++) begin : g_buf
			always_ff @(posedge core_clk) begin
				if (reset || !ctl1_reg.moduleOn) begin
					resBuf_reg[bi] <= 16'h0000;
				end else if (resultWr && bufIdx_reg == 1'(bi)) begin
					resBuf_reg[bi] <= sas_format(ctl1_reg.outputFormat, convResult);
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sampling_reg <= 1'b0;
			convStart_reg <= 1'b0;
			muxSelB_reg <= 1'b0;
			scanStep_reg <= 1'b0;
			refPosExt_reg <= 1'b0;
			refNegExt_reg <= 1'b0;
			calibrate_reg <= 1'b0;
			pumpOn_reg <= 1'b0;
			rcSelect_reg <= 1'b0;
			intFlag_reg <= 1'b0;
			active_reg <= 1'b0;
		end else begin
			sampling_reg <= (state_next == sas_pkg::ST_SAMPLE);
			convStart_reg <= convStart_next;
			muxSelB_reg <= muxB_next && !calOn;
			scanStep_reg <= scanStep_next;
			refPosExt_reg <= (ctl2_reg.referenceSelect == sas_pkg::REF_POS_EXT) ||
				(ctl2_reg.referenceSelect == sas_pkg::REF_BOTH_EXT);
			refNegExt_reg <= (ctl2_reg.referenceSelect == sas_pkg::REF_NEG_EXT) ||
				(ctl2_reg.referenceSelect == sas_pkg::REF_BOTH_EXT);
			calibrate_reg <= calOn;
			pumpOn_reg <= ctl3_reg.chargePumpEnable;
			rcSelect_reg <= ctl3_reg.clockSourceRc;
			intFlag_reg <= intPulse_next;
			active_reg <= ctl1_reg.moduleOn && !idleHalt;
		end
	end

	assign hrdata = hrdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp = 1'b0;
	assign sampling = sampling_reg;
	assign convStart = convStart_reg;
	assign muxSelB = muxSelB_reg;
	assign scanStep = scanStep_reg;
	assign refPosExt = refPosExt_reg;
	assign refNegExt = refNegExt_reg;
	assign calibrate = calibrate_reg;
	assign pumpOn = pumpOn_reg;
	assign rcSelect = rcSelect_reg;
	assign converterIntFlag = intFlag_reg;
	assign moduleActive = active_reg;
endmodule
`default_nettype wire

// *** sim/sas_sequencer_sva.sv ***
`default_nettype none
module sas_sequencer_chk (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic sampling,
	input wire logic convStart,
	input wire logic muxSelB,
	input wire logic scanStep,
	input wire logic calibrate,
	input wire logic converterIntFlag,
	input wire logic moduleActive
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	// an interrupt event closes a conversion: sampling was over, no new start, module running
	sequence s_conv_seen;
		$past(!sampling) ##0 !convStart ##0 moduleActive;
	endsequence

	property p_bus_okay;
		hreadyout && !hresp;
	endproperty
	property p_reset_quiet;
		$fell(reset) |-> !sampling && !convStart && !converterIntFlag && !moduleActive;
	endproperty
	property p_start_pulse;
		convStart |=> !convStart;
	endproperty
	property p_int_pulse;
		converterIntFlag |=> !converterIntFlag;
	endproperty
	property p_off_no_start;
		!moduleActive && $past(!moduleActive) |-> !convStart;
	endproperty
	property p_cal_plain;
		calibrate && $past(calibrate) |-> !muxSelB && !scanStep;
	endproperty
	property p_start_from_sample;
		convStart |-> sampling || $past(sampling);
	endproperty
	property p_int_after_done;
		converterIntFlag |-> s_conv_seen;
	endproperty

	a_bus_okay: assert property (p_bus_okay)
		else $error("bus answer not ready or not okay");
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("outputs active right after reset");
	a_start_pulse: assert property (p_start_pulse)
		else $error("conversion start longer than one cycle");
	a_int_pulse: assert property (p_int_pulse)
		else $error("interrupt event longer than one cycle");
	a_off_no_start: assert property (p_off_no_start)
		else $error("conversion started while module inactive");
	a_cal_plain: assert property (p_cal_plain)
		else $error("channel selection moved under calibration");
	a_start_from_sample: assert property (p_start_from_sample)
		else $error("conversion started without sampling");
	a_int_after_done: assert property (p_int_after_done)
		else $error("interrupt event without finished conversion");
endmodule

bind sas_sequencer sas_sequencer_chk i_chk (.core_clk(core_clk), .reset(reset),
	.hreadyout(hreadyout), .hresp(hresp), .sampling(sampling),
	.convStart(convStart), .muxSelB(muxSelB), .scanStep(scanStep), .calibrate(calibrate),
	.converterIntFlag(converterIntFlag), .moduleActive(moduleActive));
`default_nettype wire

// *** sim/tb_top.sv ***
`default_nettype none
`define CHK(nm, ex, gt) begin checksDone++; if ((gt) !== (ex)) begin errors++; \
	$display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic        idleMode = 1'b0, timerMatch = 1'b0, extIntZero = 1'b0, rcClock = 1'b0;
	logic        convDone = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [9:0]  convResult = 10'h000;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h27311a4c;
	logic        hreadyout, hresp, sampling, convStart, muxSelB, scanStep, refPosExt;
	logic        refNegExt, calibrate, pumpOn, rcSelect, converterIntFlag, moduleActive;
	int          errors = 0, checksDone = 0, cycles = 0, starts = 0, ints = 0, steps = 0;
	logic [7:0]  offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};

	sas_sequencer i_sas_sequencer (.core_clk(core_clk), .reset(reset), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.idleMode(idleMode), .timerMatch(timerMatch), .extIntZero(extIntZero),
		.rcClock(rcClock), .convDone(convDone), .convResult(convResult),
		.sampling(sampling), .convStart(convStart), .muxSelB(muxSelB), .scanStep(scanStep),
		.refPosExt(refPosExt), .refNegExt(refNegExt), .calibrate(calibrate),
		.pumpOn(pumpOn), .rcSelect(rcSelect), .converterIntFlag(converterIntFlag),
		.moduleActive(moduleActive));

	initial forever #20 core_clk = ~core_clk;

	// start, interrupt and step counters move by nonblocking update so a read right after an edge is never racy
	always @(posedge core_clk) begin
		rcClock <= ~rcClock;
		starts <= starts + (convStart === 1'b1);
		ints <= ints + (converterIntFlag === 1'b1);
		steps <= steps + (scanStep === 1'b1);
		cycles++;
		if (cycles == 20000) begin
			errors++;
			endSim();
		end
	end

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [15:0] fmtv(input logic [1:0] f, input logic [9:0] r);
		logic [9:0] s;
		s = r ^ 10'h200;
		case (f)
			2'h0: return {6'h00, r};
			2'h1: return {{6{s[9]}}, s};
			2'h2: return {r, 6'h00};
			default: return {s, 6'h00};
		endcase
	endfunction

	task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d,
		output logic [31:0] q);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {seed[31:16], d};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
		logic [31:0] q;
		bus(a, 1'b0, 16'h0000, q);
		`CHK(nm, ex, q)
	endtask

	task automatic waitfor(ref int c, input int old);
		for (int i = 0; i < 40 && c == old; i++) @(posedge core_clk);
	endtask

	task automatic conv(input logic [9:0] raw);
		@(posedge core_clk);
		convResult <= raw;
		convDone <= 1'b1;
		repeat (8) @(posedge core_clk);
		convDone <= 1'b0;
		convResult <= ~raw;
	endtask

	// pulses sit well apart so the input synchronisers see each edge cleanly
	task automatic pulse(input logic t, input logic e);
		@(posedge core_clk);
		timerMatch <= t;
		extIntZero <= e;
		repeat (4) @(posedge core_clk);
		timerMatch <= 1'b0;
		extIntZero <= 1'b0;
		repeat (8) @(posedge core_clk);
	endtask

	task endSim();
		$display("checks %0d errors %0d", checksDone, errors);
		if (errors == 0 && checksDone > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		logic [31:0] q;
		logic [15:0] d;
		logic [1:0]  f;
		int          n, ni, ns, k, gap;
		f = 2'h0;
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		foreach (offs[i]) rdchk(offs[i], 32'h0, "reset value");
		for (k = 0; k < 8; k++) begin
			void'(rnd());
			d = seed[15:0];
			d[15:13] = k[2:0];
			wr(8'h00, d & 16'h7fff);
			rdchk(8'h00, {16'h0000, d & 16'h23e4}, "control one");
			wr(8'h04, d);
			rdchk(8'h04, {16'h0000, d & 16'hf43d}, "control two");
			`CHK("ref pos", k < 4 && k[0], refPosExt)
			`CHK("ref neg", k < 4 && k[1], refNegExt)
			`CHK("calibrate", d[12], calibrate)
			wr(8'h08, d ^ 16'h4000);
			rdchk(8'h08, {16'h0000, d & 16'hbf3f}, "control three");
			`CHK("rc select", d[15], rcSelect)
			`CHK("pump", d[13], pumpOn)
		end
		for (int r = 0; r < 3; r++) begin
			wr(8'h00, 16'h0000);
			rdchk(8'h0c, 32'h0, "buffer after off");
			wr(8'h04, 16'h0401 | 16'(r << 2));
			// module on first: a write that also turns it on drops sample_enable
			wr(8'h00, 16'h8000);
			ni = ints;
			ns = steps;
			for (int j = 0; j <= r; j++) begin
				wr(8'h00, 16'h8002 | {6'h00, f, 8'h00});
				n = starts;
				wr(8'h00, 16'h8000 | {6'h00, f, 8'h00});
				waitfor(starts, n);
				`CHK("start", n + 1, starts)
				rdchk(8'h00, {16'h0000, 16'h8000 | {6'h00, f, 8'h00}}, "pending");
				void'(rnd());
				conv(seed[9:0]);
				repeat (3) @(posedge core_clk);
				rdchk(j % 2 ? 8'h10 : 8'h0c, {16'h0000, fmtv(f, seed[9:0])}, "result");
				rdchk(8'h00, {16'h0000, 16'h8001 | {6'h00, f, 8'h00}}, "done");
				`CHK("mux b", ~j[0], muxSelB)
				f++;
			end
			`CHK("interrupts", ni + 1, ints)
			`CHK("scan steps", ns + r / 2 + 1, steps)
		end
		for (k = 1; k < 4; k++) begin
			wr(8'h00, 16'h8002 | {8'h00, k[2:0], 5'h00});
			wr(8'h00, 16'h8000 | {8'h00, k[2:0], 5'h00});
			bus(8'h08, 1'b0, 16'h0000, q);
			`CHK("extended", 1'b1, q[14])
			n = starts;
			pulse(k != 2, k != 1);
			`CHK("wrong source", n, starts)
			pulse(k != 1, k != 2);
			`CHK("trigger", n + (k < 3), starts)
			bus(8'h08, 1'b0, 16'h0000, q);
			`CHK("extended end", k == 3, q[14])
			if (k < 3)
				conv(seed[9:0]);
		end
		wr(8'h00, 16'h0000);
		wr(8'h04, 16'h0000);
		wr(8'h08, 16'h0301);
		n = starts;
		wr(8'h00, 16'h80e4);
		waitfor(starts, n);
		repeat (2) @(posedge core_clk);
		convResult <= 10'h155;
		convDone <= 1'b1;
		for (gap = 0; gap < 40 && sampling !== 1'b1; gap++) @(posedge core_clk);
		n = starts;
		for (gap = 0; gap < 40 && starts == n; gap++) @(posedge core_clk);
		`CHK("auto restart", n + 1, starts)
		`CHK("auto gap", 1'b1, gap >= 5 && gap <= 10)
		convDone <= 1'b0;
		conv(10'h2aa);
		wr(8'h00, 16'h0000);
		wr(8'h00, 16'ha000);
		wr(8'h00, 16'ha002);
		idleMode <= 1'b1;
		n = starts;
		wr(8'h00, 16'ha000);
		repeat (10) @(posedge core_clk);
		`CHK("halted", n, starts)
		`CHK("idle inactive", 1'b0, moduleActive)
		idleMode <= 1'b0;
		waitfor(starts, n);
		`CHK("resumed", n + 1, starts)
		conv(10'h3ff);
		wr(8'h00, 16'h8000);
		idleMode <= 1'b1;
		repeat (6) @(posedge core_clk);
		`CHK("idle active", 1'b1, moduleActive)
		idleMode <= 1'b0;
		repeat (4) @(posedge core_clk);
		endSim();
	end
endmodule
`default_nettype wire
